// ===== cle_pkg.sv
// ============================================================
// Shared constants of the configurable logic engine.
package cle_pkg;

  // ============================================================
  // Timing: one evaluation pass every two milliseconds.
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned TICK_NS = 2000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [15:0] TICK_MS = 16'h0002;

  // ============================================================
  // Register offsets (byte addresses of 32-bit words).
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CNT = 8'h08;
  localparam logic [7:0] A_GSEL = 8'h10;
  localparam logic [7:0] A_GMODE = 8'h30;
  localparam logic [7:0] A_LATCH = 8'h50;
  localparam logic [7:0] A_PDCFG = 8'h54;
  localparam logic [7:0] A_PDDLY = 8'h58;
  localparam logic [7:0] A_SRCFG = 8'h5c;
  localparam logic [7:0] A_SRDLY = 8'h60;
  localparam logic [7:0] A_CTCFG = 8'h64;
  localparam logic [7:0] A_CTTHR = 8'h68;
  localparam logic [7:0] A_OSEL = 8'h70;
  localparam logic [7:0] A_SLOT_MASK = 8'he0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // ============================================================
  // Gate mode word fields.
  localparam int unsigned GM_INV_LO = 2;
  localparam int unsigned GM_OUT_INV = 6;

  // ============================================================
  // Flag and primitive output indices seen by every select field.
  localparam logic [6:0] F_NONE = 7'h00;
  localparam logic [6:0] F_USER_FIRST = 7'h19;
  localparam logic [6:0] F_USER_LAST = 7'h20;
  localparam logic [6:0] F_TRIP = 7'h21;
  localparam logic [6:0] P_GATE = 7'h40;
  localparam logic [6:0] P_LATCH = 7'h48;
  localparam logic [6:0] P_PDT = 7'h49;
  localparam logic [6:0] P_SRX = 7'h4a;
  localparam logic [6:0] P_SRC = 7'h4b;
  localparam logic [6:0] P_CNT = 7'h4c;

  typedef enum logic [1:0] {CLE_AND, CLE_OR, CLE_NOT} cle_gate_t;

endpackage : cle_pkg

// ===== cle_engine.sv
// Notes on behaviour
// - The whole network is evaluated once per tick, every 2 ms.
// - Each gate in series adds one tick of latency.
// - A flag routed straight to a contact bypasses the tick.
// - Trip flag 33 through one gate gains at most one tick.
// - Gates are AND, OR or NOT with up to four inputs.
// - Every gate input can be inverted on its own.
// - Every gate output can be inverted.
// - The latch takes data while strobe is high, ignores it when low.
// - The latch output shows the stored bit.
// - Pickup timer output rises after input high for the pickup time.
// - A falling input clears accumulated pickup time at once.
// - Output holds while input high, then for the dropout time.
// - Dropout timing finishes even if the input returns high.
// - Pickup and dropout run independently of each other.
// - Delay timer comes out of reset idle with both outputs low.
// - Set starts timing and drops both outputs; at the delay expired rises.
// - A rising reset while idle drives both outputs low.
// - Each rising count input adds exactly one, up to 65535, unless a reset edge comes in the same pass.
// - Counter output is high when count reaches the threshold.
// - A rising counter reset input clears the count.
`timescale 1ns/1ns
module cle_engine #(
  parameter int unsigned TICK_CYCLES = cle_pkg::TICK_CYC,
  parameter int unsigned NG = 4,
  parameter int unsigned NO = 4
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [63:0] FLAGS,
  input wire logic [7:0] USER_IN,
  output logic [NO-1:0] CONTACT
);

  // ============================================================
  // State.
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TLAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [7:0] u1;
    logic [7:0] u2;
    logic [TW-1:0] tdiv;
    logic [31:0] ctrl;
    logic [NG-1:0][31:0] gsel;
    logic [NG-1:0][7:0] gmode;
    logic [NG-1:0] gate;
    logic [15:0] lcfg;
    logic q;
    logic [15:0] pcfg;
    logic [31:0] pdly;
    logic [15:0] pu;
    logic [15:0] dcnt;
    logic drop;
    logic pout;
    logic [15:0] scfg;
    logic [15:0] sdly;
    logic [15:0] scnt;
    logic stim;
    logic so;
    logic ro;
    logic s_prev;
    logic r_prev;
    logic [15:0] ccfg;
    logic [15:0] cthr;
    logic [15:0] cnt;
    logic cs_prev;
    logic cr_prev;
    logic [NO-1:0][7:0] osel;
    logic [NO-1:0] contact;
    logic [31:0] rdata;
  } cle_state_t;

  cle_state_t st_r;
  cle_state_t st_nxt;
  logic [127:0] sig;
  logic tick;

  // ============================================================
  // Helpers.

  // Unused inputs (select zero) drop out, so a two-input AND works.
  function automatic logic cle_gate(logic [3:0] v, logic [3:0] used,
                                    logic [7:0] mode);
    logic [3:0] x;
    logic r;
    x = v ^ mode[cle_pkg::GM_INV_LO +: 4];
    unique case (mode[1:0])
      cle_pkg::CLE_AND: r = &(x | ~used);
      cle_pkg::CLE_OR: r = |(x & used);
      cle_pkg::CLE_NOT: r = ~x[0];
      default: r = 1'b0;
    endcase
    return r ^ mode[cle_pkg::GM_OUT_INV];
  endfunction : cle_gate

  // Saturating millisecond accumulator, so a long hold never wraps.
  function automatic logic [15:0] cle_inc(logic [15:0] a);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, cle_pkg::TICK_MS};
    return s[16] ? 16'hffff : s[15:0];
  endfunction : cle_inc

  // Word index of an address within a bank that starts at base. An address
  // below the bank wraps to a large index, so one compare bounds both ends.
  function automatic int unsigned cle_slot(logic [7:0] a, logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return 32'(d[7:2]);
  endfunction : cle_slot

  // ============================================================
  // Signal space: flags 0..63, primitive outputs from 64 upward.
  // Index 0 always reads low; user inputs replace flags 25..32.
  always_comb begin
    sig = '0;
    sig[63:1] = FLAGS[63:1];
    sig[cle_pkg::F_USER_FIRST +: 8] = st_r.u2;
    sig[cle_pkg::P_GATE +: NG] = st_r.gate;
    sig[cle_pkg::P_LATCH] = st_r.q;
    sig[cle_pkg::P_PDT] = st_r.pout;
    sig[cle_pkg::P_SRX] = st_r.so;
    sig[cle_pkg::P_SRC] = st_r.ro;
    sig[cle_pkg::P_CNT] = st_r.cnt >= st_r.cthr;
  end

  assign tick = (st_r.tdiv == TLAST) && st_r.ctrl[0];

  // ============================================================
  // Next state.
  always_comb begin
    logic [3:0] gv;
    logic [3:0] gu;
    logic pin;
    logic srs;
    logic srr;
    logic cs;
    logic cr;
    logic [15:0] pu_n;
    logic [31:0] rd;
    int unsigned kg;
    int unsigned km;
    int unsigned ko;
    gv = '0;
    gu = '0;
    pu_n = '0;
    rd = '0;
    kg = cle_slot(ADDR, cle_pkg::A_GSEL);
    km = cle_slot(ADDR, cle_pkg::A_GMODE);
    ko = cle_slot(ADDR, cle_pkg::A_OSEL);
    st_nxt = st_r;
    // Pins are asynchronous; two stages before anything reads them.
    st_nxt.u1 = USER_IN;
    st_nxt.u2 = st_r.u1;
    st_nxt.tdiv = (st_r.tdiv == TLAST) ? '0 : st_r.tdiv + TW'(1);
    pin = sig[st_r.pcfg[6:0]];
    srs = sig[st_r.scfg[6:0]];
    srr = sig[st_r.scfg[14:8]];
    cs = sig[st_r.ccfg[6:0]];
    cr = sig[st_r.ccfg[14:8]];

    // Every primitive reads the previous pass, so each stage of a chain
    // adds one tick; the trip flag through one gate gains at most one tick.
    if (tick) begin
      for (int g = 0; g < NG; g++) begin
        for (int i = 0; i < 4; i++) begin
          gv[i] = sig[st_r.gsel[g][8*i +: 7]];
          gu[i] = st_r.gsel[g][8*i +: 7] != cle_pkg::F_NONE;
        end
        st_nxt.gate[g] = cle_gate(gv, gu, st_r.gmode[g]);
      end

      // Transparent latch sampled once per pass.
      if (sig[st_r.lcfg[14:8]]) begin
        st_nxt.q = sig[st_r.lcfg[6:0]];
      end

      // Pickup/dropout timer: pickup clears on any low input.
      pu_n = pin ? cle_inc(st_r.pu) : '0;
      st_nxt.pu = pu_n;
      if (st_r.drop) begin
        st_nxt.dcnt = cle_inc(st_r.dcnt);
        if (st_nxt.dcnt >= st_r.pdly[31:16]) begin
          st_nxt.drop = 1'b0;
        end
      end else if (st_r.pout && !pin) begin
        st_nxt.drop = 1'b1;
        st_nxt.dcnt = '0;
      end
      // Pickup keeps counting during dropout, independently.
      st_nxt.pout = st_nxt.drop ||
                    (pin && pu_n >= st_r.pdly[15:0]);

      // Set/reset pickup delay timer.
      st_nxt.s_prev = srs;
      st_nxt.r_prev = srr;
      if (st_r.stim) begin
        if (srr) begin
          st_nxt.stim = 1'b0;
          st_nxt.ro = 1'b1;
          st_nxt.so = 1'b0;
        end else begin
          st_nxt.scnt = cle_inc(st_r.scnt);
          if (st_nxt.scnt >= st_r.sdly) begin
            st_nxt.stim = 1'b0;
            st_nxt.so = 1'b1;
            st_nxt.ro = 1'b0;
          end
        end
      end else if (srr && !st_r.r_prev) begin
        // Only a rising reset clears an idle timer, so a reset still held
        // after an abort leaves the cleared output up.
        st_nxt.so = 1'b0;
        st_nxt.ro = 1'b0;
      end else if (srs && !st_r.s_prev) begin
        st_nxt.stim = 1'b1;
        st_nxt.scnt = '0;
        st_nxt.so = 1'b0;
        st_nxt.ro = 1'b0;
      end else if (!srs) begin
        st_nxt.so = 1'b0;
      end

      // Counter: reset edge wins over a count edge in the same pass.
      st_nxt.cs_prev = cs;
      st_nxt.cr_prev = cr;
      if (cr && !st_r.cr_prev) begin
        st_nxt.cnt = '0;
      end else if (cs && !st_r.cs_prev && st_r.cnt != 16'hffff) begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end

    // Contacts follow their source every clock, not every tick.
    for (int j = 0; j < NO; j++) begin
      st_nxt.contact[j] = sig[st_r.osel[j][6:0]];
    end

    // Register writes.
    if (WR) begin
      if (kg < NG) begin
        st_nxt.gsel[kg] = WDATA;
      end
      if (km < NG) begin
        st_nxt.gmode[km] = WDATA[7:0];
      end
      if (ko < NO) begin
        st_nxt.osel[ko] = WDATA[7:0];
      end
      unique case (ADDR)
        cle_pkg::A_CTRL: st_nxt.ctrl = {31'h0, WDATA[0]};
        cle_pkg::A_LATCH: st_nxt.lcfg = WDATA[15:0];
        cle_pkg::A_PDCFG: st_nxt.pcfg = WDATA[15:0];
        cle_pkg::A_PDDLY: st_nxt.pdly = WDATA;
        cle_pkg::A_SRCFG: st_nxt.scfg = WDATA[15:0];
        cle_pkg::A_SRDLY: st_nxt.sdly = WDATA[15:0];
        cle_pkg::A_CTCFG: st_nxt.ccfg = WDATA[15:0];
        cle_pkg::A_CTTHR: st_nxt.cthr = WDATA[15:0];
        default: ;
      endcase
    end

    // Register reads; unmapped words read zero.
    if (kg < NG) begin
      rd = st_r.gsel[kg];
    end else if (km < NG) begin
      rd = {24'h0, st_r.gmode[km]};
    end else if (ko < NO) begin
      rd = {24'h0, st_r.osel[ko]};
    end else begin
      unique case (ADDR)
        cle_pkg::A_CTRL: rd = st_r.ctrl;
        cle_pkg::A_STAT: rd = {16'h0, 3'h0, sig[cle_pkg::P_CNT],
                               st_r.ro, st_r.so, st_r.pout, st_r.q,
                               8'(st_r.gate)};
        cle_pkg::A_CNT: rd = {16'h0, st_r.cnt};
        cle_pkg::A_LATCH: rd = {16'h0, st_r.lcfg};
        cle_pkg::A_PDCFG: rd = {16'h0, st_r.pcfg};
        cle_pkg::A_PDDLY: rd = st_r.pdly;
        cle_pkg::A_SRCFG: rd = {16'h0, st_r.scfg};
        cle_pkg::A_SRDLY: rd = {16'h0, st_r.sdly};
        cle_pkg::A_CTCFG: rd = {16'h0, st_r.ccfg};
        cle_pkg::A_CTTHR: rd = {16'h0, st_r.cthr};
        default: rd = '0;
      endcase
    end
    st_nxt.rdata = RD ? rd : '0;
  end

  // ============================================================
  // The single state register.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
      st_r.ctrl <= cle_pkg::CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata;
  assign CONTACT = st_r.contact;

  // ============================================================
  // Checks.
  default clocking cle_cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  logic pin_c;
  logic srs_c;
  logic srr_c;
  logic cs_c;
  logic cr_c;
  assign pin_c = sig[st_r.pcfg[6:0]];
  assign srs_c = sig[st_r.scfg[6:0]];
  assign srr_c = sig[st_r.scfg[14:8]];
  assign cs_c = sig[st_r.ccfg[6:0]];
  assign cr_c = sig[st_r.ccfg[14:8]];
  logic dir0_c;
  logic lat_d_c;
  assign dir0_c = sig[st_r.osel[0][6:0]];
  assign lat_d_c = sig[st_r.lcfg[6:0]];

  a_tick_spacing: assert property (
    tick |=> !tick [*2])
    else $error("Evaluation ticks too close together.");

  a_gate_only_on_tick: assert property (
    !tick |=> $stable(st_r.gate))
    else $error("Gate output moved between ticks.");

  a_direct_contact: assert property (
    ##1 CONTACT[0] == $past(dir0_c))
    else $error("Direct contact did not follow its flag in one clock.");

  a_latch_hold: assert property (
    tick && !sig[st_r.lcfg[14:8]] |=> $stable(st_r.q))
    else $error("Latch changed with strobe low.");

  a_latch_capture: assert property (
    tick && sig[st_r.lcfg[14:8]] |=> st_r.q == $past(lat_d_c))
    else $error("Latch did not capture data under strobe.");

  a_pickup_clear: assert property (
    tick && !pin_c |=> st_r.pu == 16'h0000)
    else $error("Pickup time survived a low input.");

  a_dropout_holds: assert property (
    st_r.drop |-> st_r.pout)
    else $error("Timer output low while dropout runs.");

  a_sr_exclusive: assert property (
    !(st_r.so && st_r.ro))
    else $error("Delay timer outputs both high.");

  a_sr_idle_reset: assert property (
    tick && !st_r.stim && srr_c && !st_r.r_prev |=> !st_r.so && !st_r.ro)
    else $error("Idle reset did not clear both outputs.");

  a_sr_abort: assert property (
    tick && st_r.stim && srr_c |=> st_r.ro && !st_r.so && !st_r.stim)
    else $error("Abort did not raise the cleared output.");

  a_count_step: assert property (
    tick && cs_c && !st_r.cs_prev && !(cr_c && !st_r.cr_prev)
      && st_r.cnt != 16'hffff |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
    else $error("Count edge did not add one.");

  a_count_clear: assert property (
    tick && cr_c && !st_r.cr_prev |=> st_r.cnt == 16'h0000)
    else $error("Counter reset edge did not clear.");

  c_pickup: cover property ($rose(st_r.pout));
  c_dropout_done: cover property ($fell(st_r.drop));
  c_sr_expired: cover property ($rose(st_r.so));
  c_count_reached: cover property ($rose(sig[cle_pkg::P_CNT]));

endmodule : cle_engine

// ===== cle_scheme_model.sv
`timescale 1ns/1ns
// ============================================================
// Scheme side model: protection flags and contact converter pins.
module cle_scheme_model (
  input wire logic CLOCK,
  output logic [63:0] FLAGS,
  output logic [7:0] USER_IN
);
  // Everything starts low so no contact closes before it is asked to.
  initial begin
    FLAGS = 64'h0;
    USER_IN = 8'h00;
  end

  // Flags move just after an edge; only listed indices are used.
  task automatic set_flag(input int i, input logic v);
    @(posedge CLOCK);
    FLAGS[i] <= v;
  endtask : set_flag

  // Contact converter pins, which the block resynchronises itself.
  task automatic set_user(input logic [7:0] v);
    @(posedge CLOCK);
    USER_IN <= v;
  endtask : set_user
endmodule : cle_scheme_model

// ===== configurable_logic_engine_tb.sv
`timescale 1ns/1ns
// ============================================================
// Bench for the logic engine with a short evaluation tick.
module configurable_logic_engine_tb;
  localparam int TK = 10;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic [63:0] FLAGS;
  logic [7:0] USER_IN;
  logic [3:0] CONTACT;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] d;
  logic x, y, e;
  int n;

  // Free running clock of 8 ns.
  always #4 CLOCK = ~CLOCK;

  cle_engine #(.TICK_CYCLES(TK)) DUT (.CLOCK(CLOCK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .FLAGS(FLAGS), .USER_IN(USER_IN), .CONTACT(CONTACT));
  cle_scheme_model scene (.CLOCK(CLOCK), .FLAGS(FLAGS),
    .USER_IN(USER_IN));

  // ============================================================
  // Bus and check helpers.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : rd

  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] g);
    cmp_count++;
    if (g !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  task automatic sb(input int b, input logic ex, input string nm);
    rd(cle_pkg::A_STAT, d);
    chk(nm, 32'(ex), 32'(d[b]));
  endtask : sb

  task automatic tk(input int t);
    repeat (t * TK) @(posedge CLOCK);
  endtask : tk

  task automatic summarize();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Whole run needs under two thousand cycles; this span is far beyond it.
  initial begin
    repeat (20000) @(posedge CLOCK);
    bad_count++;
    $display("Watchdog expired");
    summarize();
  end

  // ============================================================
  // Test sequence.
  initial begin
    repeat (10) @(posedge CLOCK);
    RST <= 1'b0;
    rd(cle_pkg::A_CTRL, d);
    chk("ctrl", cle_pkg::CTRL_RST, d);
    rd(8'hfc, d);
    chk("unmapped", 32'h0, d);
    @(posedge CLOCK);
    #1 chk("rdata_idle", 32'h0, RDATA);
    sb(10, 1'b0, "expired");
    sb(11, 1'b0, "cleared");
    $display("Test registers ended");
    // Every gate kind, inversion of inputs 0 and 1, and output inversion.
    wr(cle_pkg::A_GSEL, 32'h0000_0201);
    scene.set_flag(1, 1'b1);
    for (int t = 0; t < 3; t++) begin
      for (int inv = 0; inv < 4; inv++) begin
        for (int oi = 0; oi < 2; oi++) begin
          wr(cle_pkg::A_GMODE, {25'h0, 1'(oi), 2'h0, 2'(inv), 2'(t)});
          tk(2);
          x = 1'b1 ^ inv[0];
          y = 1'b0 ^ inv[1];
          e = (t == 0) ? (x & y) : (t == 1) ? (x | y) : !x;
          sb(0, e ^ oi[0], "gate_out");
        end
      end
    end
    $display("Test gates ended");
    // Straight path and one gate in series.
    wr(cle_pkg::A_GSEL, 32'h0000_0021);
    wr(cle_pkg::A_GMODE, 32'h0000_0001);
    wr(cle_pkg::A_OSEL, 32'h0000_0021);
    wr(cle_pkg::A_OSEL + 8'h04, 32'h0000_0040);
    tk(2);
    scene.set_flag(33, 1'b1);
    @(posedge CLOCK);
    #1 chk("direct", 32'h1, 32'(CONTACT[0]));
    n = 1;
    while (CONTACT[1] !== 1'b1 && n < 100) begin
      @(posedge CLOCK);
      #1 n++;
    end
    chk("gate_delay", 32'h1, 32'(n >= 2 && n <= TK + 2));
    $display("Test delay ended");
    // Engine disabled: primitives hold while contacts still follow.
    wr(cle_pkg::A_CTRL, 32'h0000_0000);
    scene.set_flag(33, 1'b0);
    tk(2);
    sb(0, 1'b1, "gate_hold");
    chk("direct_off", 32'h0, 32'(CONTACT[0]));
    wr(cle_pkg::A_CTRL, cle_pkg::CTRL_RST);
    tk(2);
    sb(0, 1'b0, "gate_run");
    $display("Test enable ended");
    // Latch: transparent while strobe high, holds while low.
    wr(cle_pkg::A_LATCH, 32'h0000_0403);
    scene.set_flag(3, 1'b1);
    scene.set_flag(4, 1'b1);
    tk(2);
    sb(8, 1'b1, "latch");
    scene.set_flag(4, 1'b0);
    scene.set_flag(3, 1'b0);
    tk(2);
    sb(8, 1'b1, "latch");
    scene.set_flag(4, 1'b1);
    tk(2);
    sb(8, 1'b0, "latch");
    $display("Test latch ended");
    // Counter with a threshold of three.
    wr(cle_pkg::A_CTCFG, 32'h0000_0605);
    wr(cle_pkg::A_CTTHR, 32'h0000_0003);
    for (int i = 1; i < 4; i++) begin
      scene.set_flag(5, 1'b1);
      tk(2);
      scene.set_flag(5, 1'b0);
      tk(2);
      rd(cle_pkg::A_CNT, d);
      chk("count", 32'(i), d);
      sb(12, i >= 3, "count_out");
    end
    scene.set_flag(6, 1'b1);
    tk(2);
    rd(cle_pkg::A_CNT, d);
    chk("count", 32'h0, d);
    sb(12, 1'b0, "count_out");
    $display("Test counter ended");
    // Pickup 16 ms (8 ticks), dropout 6 ms (3 ticks).
    wr(cle_pkg::A_PDDLY, 32'h0006_0010);
    wr(cle_pkg::A_PDCFG, 32'h0000_0007);
    scene.set_flag(7, 1'b1);
    tk(5);
    scene.set_flag(7, 1'b0);
    tk(1);
    scene.set_flag(7, 1'b1);
    tk(5);
    sb(9, 1'b0, "pd_out");
    tk(5);
    sb(9, 1'b1, "pd_out");
    scene.set_flag(7, 1'b0);
    tk(1);
    sb(9, 1'b1, "pd_out");
    scene.set_flag(7, 1'b1);
    tk(4);
    sb(9, 1'b0, "pd_out");
    tk(6);
    sb(9, 1'b1, "pd_out");
    scene.set_flag(7, 1'b0);
    tk(6);
    sb(9, 1'b0, "pd_out");
    $display("Test pickup ended");
    // Delay timer of 6 ms with set and reset inputs.
    wr(cle_pkg::A_SRDLY, 32'h0000_0006);
    wr(cle_pkg::A_SRCFG, 32'h0000_0908);
    scene.set_flag(8, 1'b1);
    tk(2);
    sb(10, 1'b0, "expired");
    tk(3);
    sb(10, 1'b1, "expired");
    sb(11, 1'b0, "cleared");
    scene.set_flag(8, 1'b0);
    scene.set_flag(9, 1'b1);
    tk(2);
    sb(10, 1'b0, "expired");
    sb(11, 1'b0, "cleared");
    scene.set_flag(9, 1'b0);
    scene.set_flag(8, 1'b1);
    tk(1);
    scene.set_flag(9, 1'b1);
    tk(2);
    sb(11, 1'b1, "cleared");
    sb(10, 1'b0, "expired");
    scene.set_flag(8, 1'b0);
    scene.set_flag(9, 1'b0);
    tk(2);
    sb(11, 1'b1, "cleared");
    $display("Test delay timer ended");
    // User inputs replace flags 25 to 32 on the contacts.
    scene.set_flag(25, 1'b1);
    wr(cle_pkg::A_OSEL + 8'h08, 32'h0000_0019);
    wr(cle_pkg::A_OSEL + 8'h0c, 32'h0000_0020);
    repeat (4) @(posedge CLOCK);
    #1 chk("user_in", 32'h0, 32'(CONTACT[3:2]));
    scene.set_user(8'h01);
    repeat (4) @(posedge CLOCK);
    #1 chk("user_in", 32'h1, 32'(CONTACT[3:2]));
    scene.set_user(8'h80);
    repeat (4) @(posedge CLOCK);
    #1 chk("user_in", 32'h2, 32'(CONTACT[3:2]));
    $display("Test user inputs ended");
    summarize();
  end
endmodule : configurable_logic_engine_tb
